// [design/brs_pkg.sv]
// constants, register map and sequencer states of the brownout reset supervisor
// assumes one 25 MHz clock and an AXI4-Lite master with 32-bit data
//
// Contract
// - three thresholds, four build options select roles
// - lowest threshold always resets the system
// - low option: both supply flags held zero
// - mid option: mid flag follows supply
// - high option: mid threshold resets, high flag; mid flag stays zero
// - high flag one at/below upper, high only
// - mid flag is read-only bit four
// - max option: upper threshold resets system
// - detector reset clears both supply flags
// - enabled pin: low holds reset, high runs
// - release, load, warm-up, then fetch address zero
// - watchdog overflow causes full system reset
// - unsafe supply after watchdog keeps reset held
// - disabled pin becomes input-only port bit
// - cause bits: 00 watchdog, 10 power/detector, 11 pin
package brs_pkg;

    typedef enum logic [1:0] {
        BRS_OPT_LOW  = 2'b00,
        BRS_OPT_MID  = 2'b01,
        BRS_OPT_HIGH = 2'b10,
        BRS_OPT_MAX  = 2'b11
    } brs_option_t;

    typedef enum logic [2:0] {
        BRS_ST_HOLD  = 3'b000,
        BRS_ST_PIN   = 3'b001,
        BRS_ST_INIT  = 3'b010,
        BRS_ST_WARM  = 3'b011,
        BRS_ST_RUN   = 3'b100
    } brs_state_t;

    // printed index of the flag register; byte address is four times it
    localparam logic [11:0] BRS_IDX_FLAGS   = 12'h086;
    localparam logic [11:0] BRS_IDX_STATUS  = 12'h087;
    localparam logic [11:0] BRS_IDX_MASK    = 12'h088;
    localparam int          BRS_ADDR_W      = 12;

    localparam int          BRS_BIT_CAUSE_U = 7;
    localparam int          BRS_BIT_CAUSE_L = 6;
    localparam int          BRS_BIT_HIGH    = 5;
    localparam int          BRS_BIT_MID     = 4;
    localparam logic [7:0]  BRS_FLAGS_RST   = 8'h80;
    localparam logic [7:0]  BRS_FLAGS_WMASK = 8'hc7;

    localparam logic [1:0]  BRS_CAUSE_WDT   = 2'b00;
    localparam logic [1:0]  BRS_CAUSE_DET   = 2'b10;
    localparam logic [1:0]  BRS_CAUSE_PIN   = 2'b11;

    // status / mask layout
    localparam int          BRS_EV_W        = 3;
    localparam int          BRS_EV_MID      = 0;
    localparam int          BRS_EV_HIGH     = 1;
    localparam int          BRS_EV_START    = 2;
    localparam logic [2:0]  BRS_EV_RST      = 3'h0;

    localparam logic [1:0]  BRS_RESP_OKAY   = 2'b00;
    localparam logic [1:0]  BRS_RESP_SLVERR = 2'b10;
    localparam logic [15:0] BRS_FETCH_ADDR  = 16'h0000;

    localparam int          BRS_CLK_HZ      = 25000000;
    localparam int          BRS_WARM_NS     = 2560;
    localparam int          BRS_WARM_CYC    = (BRS_WARM_NS * (BRS_CLK_HZ / 1000000) + 999) / 1000;

endpackage

// [design/brs_sync.sv]
// two-flop level synchroniser, one bit per lane
// assumes inputs are asynchronous levels; reset value is a constant
`timescale 1ns/1ns
`default_nettype none
module brs_sync #(
    parameter int         W       = 1,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic         ref_clk_in,  // system clock
    input  wire logic         rst_b_in,    // synchronous reset, low
    input  wire logic [W-1:0] async_in,    // raw levels
    output logic      [W-1:0] sync_out     // synchronised levels
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    initial begin
        if (W < 1 || W > 8) $error("brs_sync width out of range");
    end

    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
        if (!rst_b_in) begin
            meta_nxt = RST_VAL[W-1:0];
            sync_nxt = RST_VAL[W-1:0];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign sync_out = sync_r;
endmodule
`default_nettype wire

// [design/brs_supervisor.sv]
// reset supervisor: detector thresholds, reset pin, watchdog, reset sequence, register slave
// assumes comparator and pin inputs are asynchronous, watchdog pulse on ref_clk_in
`timescale 1ns/1ns
`default_nettype none
module brs_supervisor import brs_pkg::*; #(
    parameter brs_option_t DET_OPTION  = BRS_OPT_LOW,
    parameter bit          PIN_RESET_EN = 1'b1,
    parameter int          WARM_CYCLES = BRS_WARM_CYC
) (
    input  wire logic        ref_clk_in,          // 25 MHz clock
    input  wire logic        rst_b_in,            // synchronous reset, low
    input  wire logic        vdd_lt_low_in,       // 1: supply below 2.0 V
    input  wire logic        vdd_le_mid_in,       // 1: supply at/below 2.4 V
    input  wire logic        vdd_le_high_in,      // 1: supply at/below 3.6 V
    input  wire logic        rst_pin_in,          // shared reset pin level
    input  wire logic        wdt_overflow_in,     // watchdog overflow pulse
    output logic             sys_reset_out,       // system held in reset
    output logic             load_init_out,       // register initial-value load pulse
    output logic             fetch_start_out,     // start fetching pulse
    output logic [15:0]      fetch_addr_out,      // first fetch address
    output logic             shared_input_bit_out,// pin as input port bit
    output logic             irq_out,             // level interrupt
    input  wire logic [13:0] s_axi_awaddr,        // write address
    input  wire logic        s_axi_awvalid,       // write address valid
    output logic             s_axi_awready,       // write address ready
    input  wire logic [31:0] s_axi_wdata,         // write data
    input  wire logic [3:0]  s_axi_wstrb,         // write strobes
    input  wire logic        s_axi_wvalid,        // write data valid
    output logic             s_axi_wready,        // write data ready
    output logic [1:0]       s_axi_bresp,         // write response
    output logic             s_axi_bvalid,        // write response valid
    input  wire logic        s_axi_bready,        // write response ready
    input  wire logic [13:0] s_axi_araddr,        // read address
    input  wire logic        s_axi_arvalid,       // read address valid
    output logic             s_axi_arready,       // read address ready
    output logic [31:0]      s_axi_rdata,         // read data
    output logic [1:0]       s_axi_rresp,         // read response
    output logic             s_axi_rvalid,        // read data valid
    input  wire logic        s_axi_rready         // read data ready
);
    localparam int CNT_W = $clog2(WARM_CYCLES + 1);
    localparam logic [CNT_W-1:0] WARM_LAST = CNT_W'(WARM_CYCLES - 1);

    initial begin
        if (WARM_CYCLES < 1 || WARM_CYCLES > 4096) $error("warm-up count out of range");
    end

    // index decode, used by both read and write paths
    function automatic logic [2:0] reg_sel(input logic [13:0] addr);
        logic [11:0] idx;
        idx = addr[13:2];
        reg_sel = {idx == BRS_IDX_MASK, idx == BRS_IDX_STATUS, idx == BRS_IDX_FLAGS};
    endfunction

    logic [3:0] sync_q;
    logic       lt_low;
    logic       le_mid;
    logic       le_high;
    logic       pin_q;

    brs_sync #(
        .W       (4),
        .RST_VAL (8'h08)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .async_in   ({rst_pin_in, vdd_le_high_in, vdd_le_mid_in, vdd_lt_low_in}),
        .sync_out   (sync_q)
    );
    assign lt_low  = sync_q[0];
    assign le_mid  = sync_q[1];
    assign le_high = sync_q[2];
    assign pin_q   = sync_q[3];

    // detector reset sources per build option
    logic det_reset;
    logic pin_reset;
    logic mid_on;
    logic high_on;
    always_comb begin
        det_reset = lt_low;
        unique case (DET_OPTION)
            BRS_OPT_LOW:  det_reset = lt_low;
            BRS_OPT_MID:  det_reset = lt_low;
            BRS_OPT_HIGH: det_reset = lt_low | le_mid;
            BRS_OPT_MAX:  det_reset = lt_low | le_high;
        endcase
    end
    assign mid_on    = (DET_OPTION == BRS_OPT_MID) || (DET_OPTION == BRS_OPT_HIGH);
    assign high_on   = (DET_OPTION == BRS_OPT_HIGH);
    assign pin_reset = PIN_RESET_EN && !pin_q;

    brs_state_t        state_r;
    brs_state_t        state_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic [7:0]        flags_r;
    logic [7:0]        flags_nxt;
    logic [2:0]        stat_r;
    logic [2:0]        stat_nxt;
    logic [2:0]        mask_r;
    logic [2:0]        mask_nxt;
    logic              load_r;
    logic              load_nxt;
    logic              fetch_r;
    logic              fetch_nxt;
    logic              gpio_r;
    logic              gpio_nxt;
    logic              aw_got_r;
    logic              aw_got_nxt;
    logic              w_got_r;
    logic              w_got_nxt;
    logic [13:0]       waddr_r;
    logic [13:0]       waddr_nxt;
    logic [31:0]       wdata_r;
    logic [31:0]       wdata_nxt;
    logic              wstb_r;
    logic              wstb_nxt;
    logic              bvalid_r;
    logic              bvalid_nxt;
    logic [1:0]        bresp_r;
    logic [1:0]        bresp_nxt;
    logic              rvalid_r;
    logic              rvalid_nxt;
    logic [31:0]       rdata_r;
    logic [31:0]       rdata_nxt;
    logic [1:0]        rresp_r;
    logic [1:0]        rresp_nxt;

    logic       aw_take;
    logic       w_take;
    logic       wr_do;
    logic       ar_take;
    logic [2:0] wsel;
    logic [2:0] rsel;
    logic [2:0] ev;
    logic       any_rst;

    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready  = !w_got_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take  = s_axi_wvalid && s_axi_wready;
    assign wr_do   = aw_got_r && w_got_r && !bvalid_r;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign wsel    = reg_sel(waddr_r);
    assign rsel    = reg_sel(s_axi_araddr);
    // watchdog resets wherever the sequence stands
    assign any_rst = det_reset || pin_reset || wdt_overflow_in;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        load_nxt  = 1'b0;
        fetch_nxt = 1'b0;
        flags_nxt = flags_r;
        ev        = BRS_EV_RST;

        // sequence: hold while detector or watchdog stands, pin while the pin is low, init, warm-up, run
        unique case (state_r)
            BRS_ST_HOLD: begin
                // supply still unsafe after a watchdog reset keeps us here
                if (!det_reset && !wdt_overflow_in) begin
                    state_nxt = BRS_ST_PIN;
                end
            end
            BRS_ST_PIN: begin
                if (!pin_reset) begin
                    state_nxt = BRS_ST_INIT;
                    load_nxt  = 1'b1;
                end
            end
            BRS_ST_INIT: begin
                state_nxt = BRS_ST_WARM;
                cnt_nxt   = '0;
            end
            BRS_ST_WARM: begin
                cnt_nxt = cnt_r + CNT_W'(1);
                if (cnt_r == WARM_LAST) begin
                    state_nxt = BRS_ST_RUN;
                    fetch_nxt = 1'b1;
                    ev[BRS_EV_START] = 1'b1;
                end
            end
            BRS_ST_RUN: begin
                state_nxt = BRS_ST_RUN;
            end
            default: begin
                state_nxt = BRS_ST_HOLD;
            end
        endcase

        // software writes to the flag register first, hardware after so it wins
        if (wr_do && wsel[0] && wstb_r) begin
            flags_nxt = (flags_r & ~BRS_FLAGS_WMASK) | (wdata_r[7:0] & BRS_FLAGS_WMASK);
        end
        // detector reset flags win on priority over pin and watchdog
        if (det_reset) begin
            flags_nxt[BRS_BIT_CAUSE_U:BRS_BIT_CAUSE_L] = BRS_CAUSE_DET;
            state_nxt = BRS_ST_HOLD;
        end else if (pin_reset && state_r != BRS_ST_HOLD && state_r != BRS_ST_PIN) begin
            flags_nxt[BRS_BIT_CAUSE_U:BRS_BIT_CAUSE_L] = BRS_CAUSE_PIN;
            state_nxt = BRS_ST_PIN;
        end else if (wdt_overflow_in) begin
            flags_nxt[BRS_BIT_CAUSE_U:BRS_BIT_CAUSE_L] = BRS_CAUSE_WDT;
            state_nxt = BRS_ST_HOLD;
        end else if (pin_reset && state_r == BRS_ST_PIN) begin
            state_nxt = BRS_ST_PIN;
        end

        // supply flags: live comparator image, gated by option, forced low by detector reset
        flags_nxt[BRS_BIT_MID]  = mid_on && le_mid && !det_reset;
        flags_nxt[BRS_BIT_HIGH] = high_on && le_high && !det_reset;
        ev[BRS_EV_MID]  = flags_nxt[BRS_BIT_MID] && !flags_r[BRS_BIT_MID];
        ev[BRS_EV_HIGH] = flags_nxt[BRS_BIT_HIGH] && !flags_r[BRS_BIT_HIGH];

        // status: write one clears, a new event in the same cycle wins
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        if (wr_do && wsel[1] && wstb_r) begin
            stat_nxt = stat_r & ~wdata_r[BRS_EV_W-1:0];
        end
        if (wr_do && wsel[2] && wstb_r) begin
            mask_nxt = wdata_r[BRS_EV_W-1:0];
        end
        stat_nxt = stat_nxt | ev;

        // pin as plain input bit when its reset role is off
        gpio_nxt = PIN_RESET_EN ? 1'b0 : pin_q;

        if (!rst_b_in) begin
            state_nxt = BRS_ST_HOLD;
            cnt_nxt   = '0;
            load_nxt  = 1'b0;
            fetch_nxt = 1'b0;
            flags_nxt = BRS_FLAGS_RST;
            stat_nxt  = BRS_EV_RST;
            mask_nxt  = BRS_EV_RST;
            gpio_nxt  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        state_r <= state_nxt;
        cnt_r   <= cnt_nxt;
        load_r  <= load_nxt;
        fetch_r <= fetch_nxt;
        flags_r <= flags_nxt;
        stat_r  <= stat_nxt;
        mask_r  <= mask_nxt;
        gpio_r  <= gpio_nxt;
    end

    // bus slave: address and data taken in either order, one write and one read at a time
    always_comb begin
        aw_got_nxt = aw_got_r;
        w_got_nxt  = w_got_r;
        waddr_nxt  = waddr_r;
        wdata_nxt  = wdata_r;
        wstb_nxt   = wstb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (aw_take) begin
            aw_got_nxt = 1'b1;
            waddr_nxt  = s_axi_awaddr;
        end
        if (w_take) begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstb_nxt  = s_axi_wstrb[0];
        end
        if (wr_do) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = (wsel != 3'b000) ? BRS_RESP_OKAY : BRS_RESP_SLVERR;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (ar_take) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = (rsel != 3'b000) ? BRS_RESP_OKAY : BRS_RESP_SLVERR;
            rdata_nxt  = '0;
            if (rsel[0]) rdata_nxt[7:0] = flags_r;
            if (rsel[1]) rdata_nxt[BRS_EV_W-1:0] = stat_r;
            if (rsel[2]) rdata_nxt[BRS_EV_W-1:0] = mask_r;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (!rst_b_in) begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            waddr_nxt  = '0;
            wdata_nxt  = '0;
            wstb_nxt   = 1'b0;
            bvalid_nxt = 1'b0;
            bresp_nxt  = BRS_RESP_OKAY;
            rvalid_nxt = 1'b0;
            rdata_nxt  = '0;
            rresp_nxt  = BRS_RESP_OKAY;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        aw_got_r <= aw_got_nxt;
        w_got_r  <= w_got_nxt;
        waddr_r  <= waddr_nxt;
        wdata_r  <= wdata_nxt;
        wstb_r   <= wstb_nxt;
        bvalid_r <= bvalid_nxt;
        bresp_r  <= bresp_nxt;
        rvalid_r <= rvalid_nxt;
        rdata_r  <= rdata_nxt;
        rresp_r  <= rresp_nxt;
    end

    assign sys_reset_out        = (state_r != BRS_ST_RUN);
    assign load_init_out        = load_r;
    assign fetch_start_out      = fetch_r;
    assign fetch_addr_out       = BRS_FETCH_ADDR;
    assign shared_input_bit_out = gpio_r;
    assign irq_out              = |(stat_r & mask_r);
    assign s_axi_bvalid         = bvalid_r;
    assign s_axi_bresp          = bresp_r;
    assign s_axi_rvalid         = rvalid_r;
    assign s_axi_rdata          = rdata_r;
    assign s_axi_rresp          = rresp_r;
endmodule
`default_nettype wire

// [tb/brs_supervisor_checker.sv]
// pin-level assertions for the reset supervisor
// assumes it is bound onto brs_supervisor and shares its one clock
`timescale 1ns/1ns
`default_nettype none
module brs_supervisor_checker import brs_pkg::*; #(
    parameter brs_option_t DET_OPTION   = BRS_OPT_LOW,
    parameter bit          PIN_RESET_EN = 1'b1,
    parameter int          WARM_CYCLES  = BRS_WARM_CYC
) (
    input wire logic        ref_clk_in,      // clock
    input wire logic        rst_b_in,        // reset, low
    input wire logic        vdd_lt_low_in,   // below low level
    input wire logic        vdd_le_mid_in,   // at/below mid level
    input wire logic        rst_pin_in,      // reset pin
    input wire logic        wdt_overflow_in, // watchdog overflow
    input wire logic        sys_reset_out,   // held in reset
    input wire logic        load_init_out,   // load pulse
    input wire logic        fetch_start_out, // fetch pulse
    input wire logic [15:0] fetch_addr_out,  // fetch address
    input wire logic        s_axi_bvalid,    // write resp valid
    input wire logic        s_axi_bready,    // write resp ready
    input wire logic [1:0]  s_axi_bresp      // write resp
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic [15:0] since_load_r;
    logic [15:0] since_load_nxt;
    // saturates so a long run never wraps into a false match
    always_comb begin
        since_load_nxt = since_load_r;
        if (load_init_out) begin
            since_load_nxt = 16'h0001;
        end else if (since_load_r != 16'h0000 && since_load_r != 16'hffff) begin
            since_load_nxt = since_load_r + 16'h0001;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        since_load_r <= rst_b_in ? since_load_nxt : 16'h0000;
    end
    // two synchroniser flops plus the state register
    sequence s_low_held;
        vdd_lt_low_in [*3];
    endsequence
    sequence s_fetch;
        fetch_start_out && fetch_addr_out == BRS_FETCH_ADDR;
    endsequence
    a_low_resets: assert property (s_low_held |=> sys_reset_out)
        else $error("low supply did not hold reset");
    a_mid_resets: assert property (
        (vdd_le_mid_in && DET_OPTION == BRS_OPT_HIGH) [*3] |=> sys_reset_out)
        else $error("mid supply did not hold reset");
    a_pin_resets: assert property ((!rst_pin_in && PIN_RESET_EN) [*3] |=> sys_reset_out)
        else $error("low pin did not hold reset");
    a_wdt_resets: assert property (wdt_overflow_in |=> sys_reset_out)
        else $error("watchdog overflow did not reset");
    a_warm_length: assert property ($fell(sys_reset_out) |-> since_load_r == WARM_CYCLES + 1)
        else $error("run entered without load and warm-up");
    a_fetch_on_run: assert property ($fell(sys_reset_out) |-> ##[0:1] s_fetch)
        else $error("no fetch from zero at run entry");
    a_load_in_reset: assert property (load_init_out |-> sys_reset_out ##1 !load_init_out)
        else $error("load pulse outside reset or too long");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before ready");
endmodule
bind brs_supervisor brs_supervisor_checker #(.DET_OPTION(DET_OPTION),
    .PIN_RESET_EN(PIN_RESET_EN), .WARM_CYCLES(WARM_CYCLES)) brs_supervisor_checker_inst (
    .ref_clk_in, .rst_b_in, .vdd_lt_low_in, .vdd_le_mid_in, .rst_pin_in, .wdt_overflow_in,
    .sys_reset_out, .load_init_out, .fetch_start_out, .fetch_addr_out,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);
`default_nettype wire

// [tb/brs_supply_model.sv]
// supply comparators and board reset circuit, driven from a millivolt level
// assumes the bench moves the level just after a clock edge
`timescale 1ns/1ns
`default_nettype none
module brs_supply_model #(
    parameter int LOW_MV  = 2000,
    parameter int MID_MV  = 2400,
    parameter int HIGH_MV = 3600
) (
    input  wire logic        ref_clk_in,   // clock
    input  wire logic [15:0] supply_mv_in, // supply level
    input  wire logic        pin_low_in,   // press reset
    output logic             lt_low_out,   // below low
    output logic             le_mid_out,   // at/below mid
    output logic             le_high_out,  // at/below high
    output logic             pin_out       // reset pin level
);
    // one edge of lag stands in for the analog settling time
    always_ff @(posedge ref_clk_in) begin
        lt_low_out  <= supply_mv_in < LOW_MV;
        le_mid_out  <= supply_mv_in <= MID_MV;
        le_high_out <= supply_mv_in <= HIGH_MV;
        pin_out     <= !pin_low_in;
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the supervisor built with the high detector option
// assumes the supply model feeds the comparator and pin inputs
`timescale 1ns/1ns
`default_nettype none
module tb;
    import brs_pkg::*;
    localparam logic [13:0] A_FLG = {BRS_IDX_FLAGS, 2'b00};
    localparam logic [13:0] A_STS = {BRS_IDX_STATUS, 2'b00};
    localparam logic [13:0] A_MSK = {BRS_IDX_MASK, 2'b00};
    logic ref_clk_in = 1'b0, rst_b_in = 1'b0, pin_low = 1'b0, wdt_overflow_in = 1'b0;
    logic [15:0] mv = 16'h1388;
    logic vdd_lt_low_in, vdd_le_mid_in, vdd_le_high_in, rst_pin_in, sys_reset_out;
    logic load_init_out, fetch_start_out, shared_input_bit_out, irq_out;
    logic [15:0] fetch_addr_out;
    logic [13:0] s_axi_awaddr = 14'h0000, s_axi_araddr = 14'h0000;
    logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] d;
    int n_errors = 0, comparisons = 0;
    always #20 ref_clk_in = ~ref_clk_in;
    brs_supply_model brs_supply_model_inst (.ref_clk_in, .supply_mv_in(mv),
        .pin_low_in(pin_low), .lt_low_out(vdd_lt_low_in), .le_mid_out(vdd_le_mid_in),
        .le_high_out(vdd_le_high_in), .pin_out(rst_pin_in));
    brs_supervisor #(.DET_OPTION(BRS_OPT_HIGH), .PIN_RESET_EN(1'b1), .WARM_CYCLES(2))
    brs_supervisor_inst (.ref_clk_in, .rst_b_in, .vdd_lt_low_in, .vdd_le_mid_in,
        .vdd_le_high_in, .rst_pin_in, .wdt_overflow_in, .sys_reset_out, .load_init_out,
        .fetch_start_out, .fetch_addr_out, .shared_input_bit_out, .irq_out, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [13:0] a, input logic [7:0] v, input logic [1:0] r_exp);
        @(posedge ref_clk_in);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h000000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge ref_clk_in);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        // a late ready exercises the held response
        repeat ($urandom_range(2)) @(posedge ref_clk_in);
        s_axi_bready <= 1'b1;
        do @(posedge ref_clk_in); while (!s_axi_bvalid);
        check({30'h0, s_axi_bresp}, {30'h0, r_exp});
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [13:0] a, input logic [7:0] exp, input logic [1:0] r_exp);
        @(posedge ref_clk_in);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge ref_clk_in); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge ref_clk_in); while (!s_axi_rvalid);
        check(s_axi_rdata, {24'h000000, exp});
        check({30'h0, s_axi_rresp}, {30'h0, r_exp});
        s_axi_rready <= 1'b0;
    endtask
    // high option: the mid comparator (at or below) holds reset, as does a pressed pin
    function automatic logic reset_expected(input logic [15:0] v, input logic pin);
        return (v <= 16'h0960) || pin;
    endfunction
    task automatic wait_run(input logic seen_in);
        logic seen;
        seen = seen_in;
        do begin
            @(posedge ref_clk_in);
            seen |= load_init_out;
        end while (sys_reset_out);
        check({31'h0, seen}, 32'h1);
    endtask
    task automatic upset(input logic [15:0] v, input logic pin, input logic wdt);
        logic seen;
        seen    = 1'b0;
        mv      <= v;
        pin_low <= pin;
        tick($urandom_range(8, 12));
        wdt_overflow_in <= wdt;
        tick(1);
        wdt_overflow_in <= 1'b0;
        tick(1);
        check({31'h0, sys_reset_out}, 32'h1);
        // a watchdog-only reset finishes its sequence inside this span
        repeat (20) begin
            @(posedge ref_clk_in);
            seen |= load_init_out;
        end
        check({31'h0, sys_reset_out}, {31'h0, reset_expected(v, pin)});
        mv      <= 16'h1388;
        pin_low <= 1'b0;
        wait_run(seen);
    endtask
    initial begin
        void'($urandom(32'hd0cf564c));
        tick(2);
        rst_b_in <= 1'b1;
        wait_run(1'b0);
        rd(A_FLG, 8'h80, BRS_RESP_OKAY);
        rd(A_STS, 8'h04, BRS_RESP_OKAY);
        check({31'h0, irq_out}, 32'h0);
        wr(A_MSK, 8'h04, BRS_RESP_OKAY);
        tick(1);
        check({31'h0, irq_out}, 32'h1);
        wr(A_STS, 8'h07, BRS_RESP_OKAY);
        tick(1);
        check({31'h0, irq_out}, 32'h0);
        $display("test power_on done");
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            wr(A_FLG, d, BRS_RESP_OKAY);
            rd(A_FLG, d & BRS_FLAGS_WMASK, BRS_RESP_OKAY);
        end
        wr(14'h0224, 8'h5a, BRS_RESP_SLVERR);
        rd(14'h0224, 8'h00, BRS_RESP_SLVERR);
        $display("test registers done");
        wr(A_FLG, 8'h00, BRS_RESP_OKAY);
        mv <= 16'h0bb8;
        tick(8);
        rd(A_FLG, 8'h20, BRS_RESP_OKAY);
        rd(A_STS, 8'h02, BRS_RESP_OKAY);
        $display("test supply_flags done");
        upset(16'h0960, 1'b0, 1'b0);
        rd(A_FLG, 8'h80, BRS_RESP_OKAY);
        wr(A_FLG, 8'h00, BRS_RESP_OKAY);
        upset(16'h0708, 1'b0, 1'b0);
        rd(A_FLG, 8'h80, BRS_RESP_OKAY);
        wr(A_FLG, 8'h00, BRS_RESP_OKAY);
        upset(16'h1388, 1'b1, 1'b0);
        rd(A_FLG, 8'hc0, BRS_RESP_OKAY);
        check({31'h0, shared_input_bit_out}, 32'h0);
        wr(A_FLG, 8'h40, BRS_RESP_OKAY);
        upset(16'h1388, 1'b0, 1'b1);
        rd(A_FLG, 8'h00, BRS_RESP_OKAY);
        upset(16'h0708, 1'b0, 1'b1);
        rd(A_FLG, 8'h80, BRS_RESP_OKAY);
        $display("test resets done");
        finish_test();
    end
    initial begin
        tick(20000);
        n_errors++;
        $display("[FAIL] %0t run did not finish", $time);
        finish_test();
    end
endmodule
`default_nettype wire
